/* File: sdl_pkg.sv */
// Shared constants for the serial converter word loader link
package sdl_pkg;
  localparam int WORD_BITS    = 16;
  localparam int SYNC_STAGES  = 2;
  localparam int FIFO_DEPTH   = 8;
  localparam int CLK_SYS_NS   = 50;
  localparam int LINK_HALF_NS = 200;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [15:0] DAC_RESET = 16'h0000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
endpackage

/* File: sdl_link_if.sv */
// Link carrier joining the host end and the converter end
`timescale 1ns/1ns
interface sdl_link_if;
  logic sclk;
  logic serialIn;
  logic frameSelN;
  logic loadOutputN;
  logic serialOut;
  modport host (output sclk, output serialIn, output frameSelN, output loadOutputN,
                input serialOut);
  modport dev  (input sclk, input serialIn, input frameSelN, input loadOutputN,
                output serialOut);
endinterface

/* File: sdl_fifo.sv */
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
module sdl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             nrst,      // Async reset, low
  input  wire logic [WIDTH-1:0] inData,    // Write data
  input  wire logic             inValid,   // Write request
  output logic                  inReady,   // Not full
  output logic      [WIDTH-1:0] outData,   // Head word
  output logic                  outValid,  // Not empty
  input  wire logic             outReady   // Drain strobe
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;
  assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign outData  = mem[rdPtr_ff[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtr_ff <= '0;
    end else if (doWr) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdPtr_ff <= '0;
    end else if (doRd) begin
      rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end
endmodule

/* File: sdl_host.sv */
// Host end: serial master sending words from a FIFO
`timescale 1ns/1ns
module sdl_host #(
  parameter int WORD_BITS = sdl_pkg::WORD_BITS,
  parameter int DEPTH     = sdl_pkg::FIFO_DEPTH
) (
  input  wire logic                 clk_sys,     // System clock
  input  wire logic                 nrst,        // Async reset, low
  input  wire logic [WORD_BITS-1:0] wrData,      // Word to send
  input  wire logic                 wrValid,     // Word offered
  output logic                      wrReady,     // FIFO has room
  input  wire logic                 autoLoad,    // 1: hold load low
  output logic      [WORD_BITS-1:0] rdData,      // Word shifted back
  output logic                      rdValid,     // One-cycle pulse
  sdl_link_if.host                  link         // Serial link
);
  initial begin
    if (WORD_BITS != 16) $error("WORD_BITS must be 16");
  end
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOW   = 3'b001,
    ST_HIGH  = 3'b010,
    ST_END   = 3'b011,
    ST_LOAD  = 3'b100
  } sdl_hst_e;
  sdl_hst_e         state_ff;
  logic [15:0]      txSh_ff;
  logic [15:0]      rxSh_ff;
  logic [4:0]       bitCnt_ff;
  logic [3:0]       divCnt_ff;
  logic [1:0]       sdoSync_ff;
  logic             sclk_ff;
  logic             sdi_ff;
  logic             fsN_ff;
  logic             ldN_ff;
  logic [15:0]      rdData_ff;
  logic             rdValid_ff;
  logic [15:0]      fifoData;
  logic             fifoValid;
  logic             tick;
  wire              takeWord = (state_ff == ST_IDLE) && fifoValid;

  sdl_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .inData   (wrData),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (takeWord)
  );

  // ==========================================================
  // Half-period tick for the generated shift clock
  assign tick = divCnt_ff == 4'(sdl_pkg::LINK_HALF_CYC - 1);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= '0;
    end else if (tick || state_ff == ST_IDLE) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= divCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdoSync_ff <= '0;
    end else begin
      sdoSync_ff <= {sdoSync_ff[0], link.serialOut};
    end
  end

  // ==========================================================
  // Frame sequencer, clock idles low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      sclk_ff   <= 1'b0;
      sdi_ff    <= 1'b0;
      fsN_ff    <= 1'b1;
      ldN_ff    <= 1'b1;
      txSh_ff   <= sdl_pkg::SHIFT_RESET;
      rxSh_ff   <= sdl_pkg::SHIFT_RESET;
      bitCnt_ff <= '0;
    end else begin
      ldN_ff <= !autoLoad && state_ff == ST_LOAD ? 1'b0 : !autoLoad;
      unique case (state_ff)
        ST_IDLE: begin
          if (fifoValid) begin
            txSh_ff   <= fifoData;
            fsN_ff    <= 1'b0;
            bitCnt_ff <= '0;
            state_ff  <= ST_LOW;
          end
        end
        ST_LOW: if (tick) begin
          sclk_ff  <= 1'b1;
          sdi_ff   <= txSh_ff[15];
          txSh_ff  <= {txSh_ff[14:0], 1'b0};
          state_ff <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          sclk_ff   <= 1'b0;
          rxSh_ff   <= {rxSh_ff[14:0], sdoSync_ff[1]};
          bitCnt_ff <= bitCnt_ff + 5'h1;
          state_ff  <= bitCnt_ff == 5'd15 ? ST_END : ST_LOW;
        end
        ST_END: if (tick) begin
          fsN_ff   <= 1'b1;
          state_ff <= autoLoad ? ST_IDLE : ST_LOAD;
        end
        ST_LOAD: if (tick) begin
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_ff  <= '0;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= state_ff == ST_END && tick;
      if (state_ff == ST_END && tick) begin
        rdData_ff <= rxSh_ff;
      end
    end
  end

  assign link.sclk        = sclk_ff;
  assign link.serialIn    = sdi_ff;
  assign link.frameSelN   = fsN_ff;
  assign link.loadOutputN = ldN_ff;
  assign rdData           = rdData_ff;
  assign rdValid          = rdValid_ff;
endmodule

/* File: sdl_device.sv */
// Converter end: serial word loader with readback and chaining
// Behaviour
// - Four host-driven wires: clock, data, frame, load
// - Sixteen-bit word, sampled on falling clock
// - First bit received is the MSB
// - Host keeps frame low across byte pairs
// - Host launches data on rising clock
// - Host master uses polarity 0, phase 1
// - Update after full word or via load
// - Load tied low updates at frame end
// - Load pulse low transfers received word
// - Converter register read back on output
// - Shift input on falling edge in frame
// - Extra pulses pass earlier bits out
// - Output repeats input sixteen clocks later
// - Frame with load high changes nothing
`timescale 1ns/1ns
module sdl_device #(
  parameter int WORD_BITS = sdl_pkg::WORD_BITS
) (
  input  wire logic                 clk_sys,    // System clock
  input  wire logic                 nrst,       // Async reset, low
  sdl_link_if.dev                   link,       // Serial link
  output logic      [WORD_BITS-1:0] dacValue,   // Converter register
  output logic                      dacUpdate   // One-cycle update pulse
);
  initial begin
    if (WORD_BITS != 16) $error("WORD_BITS must be 16");
  end
  // ==========================================================
  // Synchronisers, two stages each
  logic [1:0] sclkSy_ff;
  logic [1:0] sdiSy_ff;
  logic [1:0] fsSy_ff;
  logic [1:0] ldSy_ff;
  logic       sclkD_ff;
  logic       fsD_ff;
  logic       ldD_ff;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclkSy_ff <= '0;
      sdiSy_ff  <= '0;
      fsSy_ff   <= 2'b11;
      ldSy_ff   <= 2'b11;
    end else begin
      sclkSy_ff <= {sclkSy_ff[0], link.sclk};
      sdiSy_ff  <= {sdiSy_ff[0], link.serialIn};
      fsSy_ff   <= {fsSy_ff[0], link.frameSelN};
      ldSy_ff   <= {ldSy_ff[0], link.loadOutputN};
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclkD_ff <= 1'b0;
      fsD_ff   <= 1'b1;
      ldD_ff   <= 1'b1;
    end else begin
      sclkD_ff <= sclkSy_ff[1];
      fsD_ff   <= fsSy_ff[1];
      ldD_ff   <= ldSy_ff[1];
    end
  end
  wire inFrame  = !fsSy_ff[1];
  wire sclkFall = sclkD_ff && !sclkSy_ff[1] && inFrame;
  wire frameEnd = !fsD_ff && fsSy_ff[1];
  wire frameBeg = fsD_ff && !fsSy_ff[1];
  wire ldFall   = ldD_ff && !ldSy_ff[1];

  // ==========================================================
  // Shift path; output stream shares the register, so chaining
  // and readback need no second buffer
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [15:0] dac_ff;
  logic        sdo_ff;
  logic        upd_ff;
  always_comb begin
    nxt_shift = shift_ff;
    if (frameBeg) begin
      nxt_shift = dac_ff;
    end else if (sclkFall) begin
      nxt_shift = {shift_ff[14:0], sdiSy_ff[1]};
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= sdl_pkg::SHIFT_RESET;
    end else begin
      shift_ff <= nxt_shift;
    end
  end
  // Output shows the bit about to leave, so after 16 falls it
  // repeats input delayed by 16 clocks. Held between frames, so
  // the idle-high reset level gives no false edge on the line.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdo_ff <= 1'b1;
    end else if (frameBeg || sclkFall) begin
      sdo_ff <= nxt_shift[15];
    end
  end

  // ==========================================================
  // Converter register update
  logic written_ff;
  logic commit;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      written_ff <= 1'b0;
    end else if (frameBeg) begin
      written_ff <= 1'b0;
    end else if (sclkFall) begin
      written_ff <= 1'b1;
    end else if (commit) begin
      written_ff <= 1'b0;
    end
  end
  // Tied-low load commits at frame end; a load fall commits later.
  // A frame with no clocks or load high leaves the value alone.
  // A word commits once; a later load fall needs a new frame
  assign commit = (frameEnd && !ldSy_ff[1] && written_ff)
             || (ldFall && !inFrame && written_ff);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dac_ff <= sdl_pkg::DAC_RESET;
      upd_ff <= 1'b0;
    end else begin
      upd_ff <= commit;
      if (commit) begin
        dac_ff <= shift_ff;
      end
    end
  end

  assign link.serialOut = sdo_ff;
  assign dacValue       = dac_ff;
  assign dacUpdate      = upd_ff;
endmodule

/* File: sdl_link_sva.sv */
// Link protocol checker for the serial word loader
`timescale 1ns/1ns
module sdl_link_sva (
  input wire logic clk_sys,      // System clock
  input wire logic nrst,         // Async reset, low
  input wire logic sclk,         // Shift clock
  input wire logic serialIn,     // Host data
  input wire logic frameSelN,    // Frame select, low
  input wire logic loadOutputN,  // Load, low
  input wire logic serialOut     // Readback data
);
  logic [5:0] fallCnt_ff;
  // ==========================================
  // Falls seen inside the current frame
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fallCnt_ff <= 6'h00;
    end else if ($fell(frameSelN)) begin
      fallCnt_ff <= 6'h00;
    end else if ($fell(sclk) && !frameSelN) begin
      fallCnt_ff <= fallCnt_ff + 6'h01;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_high4; sclk[*4] ##1 !sclk; endsequence
  sequence s_low4; !sclk[*4]; endsequence
  sequence s_quiet; !sclk[*3]; endsequence
  property p_clkIdle; frameSelN |-> !sclk; endproperty
  property p_launch; !frameSelN && $stable(frameSelN) && !$rose(sclk) |-> $stable(serialIn);
  endproperty
  property p_high; $rose(sclk) |-> s_high4; endproperty
  property p_low; $fell(sclk) |-> s_low4; endproperty
  property p_bits; $rose(frameSelN) |-> fallCnt_ff == 6'h10; endproperty
  property p_quiet; $fell(frameSelN) |-> s_quiet; endproperty
  property p_loadOut; $fell(loadOutputN) |-> frameSelN; endproperty
  property p_loadLen; $fell(loadOutputN) |-> !loadOutputN[*4]; endproperty
  property p_outQuiet; frameSelN && $past(frameSelN) |-> $stable(serialOut); endproperty
  a_clkIdle: assert property (p_clkIdle)
    else $error("shift clock high outside frame");
  a_launch: assert property (p_launch)
    else $error("data moved away from a rising clock");
  a_high: assert property (p_high)
    else $error("high half period not four cycles");
  a_low: assert property (p_low)
    else $error("low half period under four cycles");
  a_bits: assert property (p_bits)
    else $error("frame closed without sixteen falls");
  a_quiet: assert property (p_quiet)
    else $error("clock rose right at frame start");
  a_loadOut: assert property (p_loadOut)
    else $error("load lowered inside a frame");
  a_loadLen: assert property (p_loadLen)
    else $error("load pulse too short");
  a_outQuiet: assert property (p_outQuiet)
    else $error("readback line moved outside frame");
endmodule

/* File: tb_serial_dac_word_loader.sv */
// Testbench joining host and converter ends over the link
`timescale 1ns/1ns
module tb_serial_dac_word_loader;
  logic        clk_sys  = 1'b0;
  logic        nrst     = 1'b0;
  logic [15:0] wrData   = 16'h0000;
  logic        wrValid  = 1'b0;
  logic        autoLoad = 1'b1;
  logic        sawFull  = 1'b0;
  logic        wrReady;
  logic [15:0] rdData;
  logic        rdValid;
  logic [15:0] dacValue;
  logic        dacUpdate;
  int          fails = 0;
  int          check_count = 0;
  int          nUpd = 0;
  int          nRd = 0;
  int          cyc = 0;
  sdl_link_if link ();
  sdl_host sdl_host_i (.clk_sys(clk_sys), .nrst(nrst), .wrData(wrData), .wrValid(wrValid),
    .wrReady(wrReady), .autoLoad(autoLoad), .rdData(rdData), .rdValid(rdValid), .link(link));
  sdl_device sdl_device_i (.clk_sys(clk_sys), .nrst(nrst), .link(link), .dacValue(dacValue),
    .dacUpdate(dacUpdate));
  sdl_link_sva sdl_link_sva_i (.clk_sys(clk_sys), .nrst(nrst), .sclk(link.sclk),
    .serialIn(link.serialIn), .frameSelN(link.frameSelN), .loadOutputN(link.loadOutputN),
    .serialOut(link.serialOut));
  always #25 clk_sys = ~clk_sys;
  // ==========================================
  // Update counting, full detection, hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (dacUpdate === 1'b1) nUpd++;
    if (rdValid === 1'b1) nRd++;
    if (wrReady === 1'b0) sawFull = 1'b1;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Valid stays up so back-to-back calls never drive it twice in one step
  task send(input logic [15:0] w);
    wrData  <= w;
    wrValid <= 1'b1;
    @(posedge clk_sys);
    while (wrReady !== 1'b1) @(posedge clk_sys);
  endtask
  task waitUpd(input int n);
    while (nUpd < n) @(posedge clk_sys);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    send(16'hc001);
    wrValid <= 1'b0;
    waitUpd(1);
    check("dacValue", dacValue, 16'hc001);
    check("rdData", rdData, 16'h0000);
    $display("test auto update done");
    autoLoad <= 1'b0;
    repeat (8) @(posedge clk_sys);
    send(16'h1234);
    wrValid <= 1'b0;
    waitUpd(2);
    check("dacValue", dacValue, 16'h1234);
    check("rdData", rdData, 16'hc001);
    repeat (40) @(posedge clk_sys);
    check("idle dacValue", dacValue, 16'h1234);
    check("updates", 16'(nUpd), 16'h0002);
    $display("test load pulse done");
    autoLoad <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) send(16'h1000 + 16'(i));
    wrValid <= 1'b0;
    waitUpd(12);
    check("burst dacValue", dacValue, 16'h1009);
    check("fifo full seen", 16'(sawFull), 16'h0001);
    check("burst rdData", rdData, 16'h1008);
    check("readbacks", 16'(nRd), 16'h000c);
    $display("test burst done");
    report_and_stop();
  end
endmodule
